// *** fsc_defines.vh ***
// constants of the serial flash host controller: register map, fields,
// opcodes and timing counts; included by the controller and its bench
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH

// register offsets
`define FSC_REG_CTRL    8'h00
`define FSC_REG_ADDR    8'h04
`define FSC_REG_LEN     8'h08
`define FSC_REG_TX      8'h0C
`define FSC_REG_RX      8'h10
`define FSC_REG_CFG     8'h14
`define FSC_REG_STATUS  8'h18

// ctrl fields
`define FSC_CTRL_START  8
`define FSC_CTRL_ABORT  9
// cfg fields
`define FSC_CFG_DC      0
`define FSC_CFG_QE      1
`define FSC_CFG_WP      2
`define FSC_CFG_HOLD    3
`define FSC_CFG_AWREN   4
`define FSC_CFG_MODE    8
// status fields
`define FSC_ST_BUSY     0
`define FSC_ST_TXFULL   1
`define FSC_ST_RXFULL   2
`define FSC_ST_DONE     3
`define FSC_ST_REFUSED  4

// reset values
`define FSC_RST_ADDR    24'h00_0000
`define FSC_RST_LEN     16'h0001
`define FSC_RST_MODE    8'h00
// third status byte: keep S23..S21 and S16, reserved bits forced to zero
`define FSC_SR3_KEEP    8'hE1

// opcodes
`define FSC_OP_WREN     8'h06
`define FSC_OP_WRDI     8'h04
`define FSC_OP_RDSR1    8'h05
`define FSC_OP_RDSR2    8'h35
`define FSC_OP_RDSR3    8'h15
`define FSC_OP_WRSR1    8'h01
`define FSC_OP_WRSR2    8'h31
`define FSC_OP_WRSR3    8'h11
`define FSC_OP_READ     8'h03
`define FSC_OP_FREAD    8'h0B
`define FSC_OP_DOREAD   8'h3B
`define FSC_OP_QOREAD   8'h6B
`define FSC_OP_DIOREAD  8'hBB
`define FSC_OP_QIOREAD  8'hEB
`define FSC_OP_PP       8'h02
`define FSC_OP_QPP      8'h32
`define FSC_OP_SE       8'h20
`define FSC_OP_BE32     8'h52
`define FSC_OP_BE64     8'hD8
`define FSC_OP_CE1      8'h60
`define FSC_OP_CE2      8'hC7
`define FSC_OP_SECER    8'h44
`define FSC_OP_SECPG    8'h42
`define FSC_OP_SECRD    8'h48
`define FSC_OP_UID      8'h4B
`define FSC_OP_RDID     8'h9F
`define FSC_OP_REMS     8'h90
`define FSC_OP_SFDP     8'h5A

// timing counts in ref_clk cycles; the dummy count is in sclk clocks
`define FSC_SCLK_HALF   8
`define FSC_CS_GAP      8
`define FSC_DUMMY_BYTE  4'd8

`endif

// *** fsc_sync.v ***
// three-stage pin synchroniser for the flash data lines
// assumes inputs asynchronous to ref_clk
`timescale 1ns/1ps
module fsc_sync #(
  parameter W = 4
)(
  input  wire         ref_clk,
  input  wire         rst,
  input  wire [W-1:0] pin,
  output reg  [W-1:0] q
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      q  <= {W{1'b0}};
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      // a change counts once stage two and three agree
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end

endmodule // fsc_sync

// *** fsc_host.v ***
// host controller for a serial nor flash on a four-wire link
// assumes a one-cycle register port and a flash that samples on rising sclk
//
// Our own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "fsc_defines.vh"
module fsc_host #(
  parameter SCLK_HALF = `FSC_SCLK_HALF,
  parameter CS_GAP    = `FSC_CS_GAP
)(
  input  wire        ref_clk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output reg         flash_cs_n,
  output reg         flash_sclk,
  input  wire [3:0]  io_in,
  output reg  [3:0]  io_out,
  output reg  [3:0]  io_oe_n
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_LAUNCH = 3'd1;
  localparam ST_SHIFT  = 3'd2;
  localparam ST_HOLD   = 3'd3;
  localparam ST_GAP    = 3'd4;

  localparam PH_OP    = 3'd0;
  localparam PH_ADDR  = 3'd1;
  localparam PH_MODE  = 3'd2;
  localparam PH_DUMMY = 3'd3;
  localparam PH_DATA  = 3'd4;
  localparam PH_DONE  = 3'd5;

  localparam DIR_NONE = 2'd0;
  localparam DIR_WR   = 2'd1;
  localparam DIR_RD   = 2'd2;

  localparam [7:0] CNT_RISE = SCLK_HALF[7:0] - 8'h01;
  localparam [7:0] CNT_LAST = {SCLK_HALF[6:0], 1'b0} - 8'h01;
  localparam [7:0] GAP_LAST = CS_GAP[7:0] - 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // opcode decode

  function [2:0] f_addr_lanes;
    input [7:0] op;
    case (op)
      `FSC_OP_DIOREAD: f_addr_lanes = 3'd2;
      `FSC_OP_QIOREAD: f_addr_lanes = 3'd4;
      default:         f_addr_lanes = 3'd1;
    endcase
  endfunction

  function [2:0] f_data_lanes;
    input [7:0] op;
    case (op)
      `FSC_OP_DOREAD, `FSC_OP_DIOREAD:              f_data_lanes = 3'd2;
      `FSC_OP_QOREAD, `FSC_OP_QIOREAD, `FSC_OP_QPP: f_data_lanes = 3'd4;
      default:                                      f_data_lanes = 3'd1;
    endcase
  endfunction

  function f_has_addr;
    input [7:0] op;
    case (op)
      `FSC_OP_READ, `FSC_OP_FREAD, `FSC_OP_DOREAD, `FSC_OP_QOREAD,
      `FSC_OP_DIOREAD, `FSC_OP_QIOREAD, `FSC_OP_PP, `FSC_OP_QPP,
      `FSC_OP_SE, `FSC_OP_BE32, `FSC_OP_BE64, `FSC_OP_SECER,
      `FSC_OP_SECPG, `FSC_OP_SECRD, `FSC_OP_UID, `FSC_OP_REMS,
      `FSC_OP_SFDP: f_has_addr = 1'b1;
      default:      f_has_addr = 1'b0;
    endcase
  endfunction

  function [1:0] f_dir;
    input [7:0] op;
    case (op)
      `FSC_OP_WRSR1, `FSC_OP_WRSR2, `FSC_OP_WRSR3, `FSC_OP_PP,
      `FSC_OP_QPP, `FSC_OP_SECPG: f_dir = DIR_WR;
      `FSC_OP_RDSR1, `FSC_OP_RDSR2, `FSC_OP_RDSR3, `FSC_OP_READ,
      `FSC_OP_FREAD, `FSC_OP_DOREAD, `FSC_OP_QOREAD, `FSC_OP_DIOREAD,
      `FSC_OP_QIOREAD, `FSC_OP_SECRD, `FSC_OP_UID, `FSC_OP_RDID,
      `FSC_OP_REMS, `FSC_OP_SFDP: f_dir = DIR_RD;
      default: f_dir = DIR_NONE;
    endcase
  endfunction

  // dummy clocks after address, mode clocks excluded
  function [3:0] f_dummy;
    input [7:0] op;
    input       dc;
    case (op)
      `FSC_OP_FREAD, `FSC_OP_DOREAD, `FSC_OP_QOREAD, `FSC_OP_SECRD,
      `FSC_OP_UID, `FSC_OP_SFDP: f_dummy = `FSC_DUMMY_BYTE;
      `FSC_OP_DIOREAD: f_dummy = dc ? 4'd4 : 4'd0; // mode 4 clocks: 4 or 8
      `FSC_OP_QIOREAD: f_dummy = dc ? 4'd8 : 4'd4; // mode 2 clocks: 6 or 10
      default:         f_dummy = 4'd0;
    endcase
  endfunction

  function f_needs_wel;
    input [7:0] op;
    case (op)
      `FSC_OP_WRSR1, `FSC_OP_WRSR2, `FSC_OP_WRSR3, `FSC_OP_PP, `FSC_OP_QPP,
      `FSC_OP_SE, `FSC_OP_BE32, `FSC_OP_BE64, `FSC_OP_CE1, `FSC_OP_CE2,
      `FSC_OP_SECER, `FSC_OP_SECPG: f_needs_wel = 1'b1;
      default: f_needs_wel = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [7:0]  cmd_op;
  reg [7:0]  cur_op;
  reg [23:0] addr_r;
  reg [15:0] len_r;
  reg [7:0]  tx_byte;
  reg        tx_full;
  reg [7:0]  rx_byte;
  reg        rx_full;
  reg        cfg_dc;
  reg        cfg_qe;
  reg        cfg_wp;
  reg        cfg_hold;
  reg        cfg_awren;
  reg [7:0]  mode_byte;
  reg        done;
  reg        refused;
  reg        abort_req;
  reg        pre;
  reg [2:0]  state;
  reg [2:0]  phase;
  reg [7:0]  cnt;
  reg [5:0]  slots;
  reg [2:0]  bslot;
  reg [15:0] bytes_left;
  reg [31:0] sh;
  reg [7:0]  rxs;
  reg [3:0]  io_dat;
  reg [3:0]  next_out;
  reg [3:0]  next_oe_n;
  reg [2:0]  nph;

  wire [3:0] io_q;
  wire [2:0] la       = f_addr_lanes(cur_op);
  wire [2:0] ld       = f_data_lanes(cur_op);
  wire [1:0] dir      = f_dir(cur_op);
  wire [3:0] dmy      = f_dummy(cur_op, cfg_dc);
  wire       has_mode = (la != 3'd1);
  wire [2:0] lanes    = (phase == PH_OP) ? 3'd1 : (phase == PH_DATA) ? ld : la;
  wire       shifting = (state == ST_SHIFT);
  wire       quad_use = (f_addr_lanes(reg_wdata[7:0]) == 3'd4) ||
                        (f_data_lanes(reg_wdata[7:0]) == 3'd4);
  wire [7:0] launch_op = pre ? `FSC_OP_WREN : cmd_op;
  wire [7:0] tx_masked = (cur_op == `FSC_OP_WRSR3) ? (tx_byte & `FSC_SR3_KEEP)
                                                   : tx_byte;
  wire       byte_start = (phase == PH_DATA) && (bslot == 3'd0);
  wire       load_tx    = byte_start && (dir == DIR_WR);
  wire       stall      = byte_start && ((dir == DIR_WR && !tx_full) ||
                                         (dir == DIR_RD && rx_full));
  wire [7:0] top        = load_tx ? tx_masked : sh[31:24];
  wire [2:0] bslot_last = (ld == 3'd4) ? 3'd1 : (ld == 3'd2) ? 3'd3 : 3'd7;
  wire       tx_now     = (phase == PH_OP) || (phase == PH_ADDR) ||
                          (phase == PH_MODE) || (phase == PH_DATA && dir == DIR_WR);
  wire       sw_wr_ctrl = reg_wr && (reg_addr == `FSC_REG_CTRL);

  fsc_sync #(
    .W (4)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin     (io_in),
    .q       (io_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next phase after the current one ends

  always @* begin
    nph = PH_DONE;
    case (phase)
      PH_OP:    nph = f_has_addr(cur_op) ? PH_ADDR : PH_DATA;
      PH_ADDR:  nph = has_mode ? PH_MODE : (dmy != 4'd0) ? PH_DUMMY : PH_DATA;
      PH_MODE:  nph = (dmy != 4'd0) ? PH_DUMMY : PH_DATA;
      PH_DUMMY: nph = PH_DATA;
      default:  nph = PH_DONE;
    endcase
    if (nph == PH_DATA && (dir == DIR_NONE || bytes_left == 16'h0000)) begin
      nph = PH_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: io2/io3 are data lines only in a quad phase

  always @* begin
    next_out  = {cfg_hold, cfg_wp, 1'b0, io_dat[0]};
    next_oe_n = 4'b0010;
    if (shifting && lanes == 3'd2) begin
      next_out[1:0]  = io_dat[1:0];
      next_oe_n[1:0] = tx_now ? 2'b00 : 2'b11;
    end else if (shifting && lanes == 3'd4) begin
      next_out  = io_dat;
      next_oe_n = tx_now ? 4'b0000 : 4'b1111;
    end
  end

  always @* begin
    io_oe_n = next_oe_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and frame engine

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cmd_op <= 8'h00;  cur_op <= 8'h00;
      addr_r <= `FSC_RST_ADDR;  len_r <= `FSC_RST_LEN;
      tx_byte <= 8'h00;  tx_full <= 1'b0;
      rx_byte <= 8'h00;  rx_full <= 1'b0;
      cfg_dc <= 1'b0;  cfg_qe <= 1'b0;
      cfg_wp <= 1'b1;  cfg_hold <= 1'b1;
      cfg_awren <= 1'b0;  mode_byte <= `FSC_RST_MODE;
      done <= 1'b0;  refused <= 1'b0;
      abort_req <= 1'b0;  pre <= 1'b0;
      state <= ST_IDLE;  phase <= PH_OP;
      cnt <= 8'h00;  slots <= 6'd0;
      bslot <= 3'd0;  bytes_left <= 16'h0000;
      sh <= 32'h0000_0000;  rxs <= 8'h00;
      io_dat <= 4'h0;  io_out <= 4'hC;
      flash_cs_n <= 1'b1;  flash_sclk <= 1'b0;
    end else begin
      io_out <= next_out;
      // software clears first so that hardware sets win
      if (reg_rd && reg_addr == `FSC_REG_RX) begin
        rx_full <= 1'b0;
      end
      if (reg_wr && reg_addr == `FSC_REG_STATUS) begin
        if (reg_wdata[`FSC_ST_DONE]) done <= 1'b0;
        if (reg_wdata[`FSC_ST_REFUSED]) refused <= 1'b0;
      end
      if (reg_wr && reg_addr == `FSC_REG_ADDR) addr_r <= reg_wdata[23:0];
      if (reg_wr && reg_addr == `FSC_REG_LEN) len_r <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `FSC_REG_CFG) begin
        cfg_dc    <= reg_wdata[`FSC_CFG_DC];
        cfg_qe    <= reg_wdata[`FSC_CFG_QE];
        cfg_wp    <= reg_wdata[`FSC_CFG_WP];
        cfg_hold  <= reg_wdata[`FSC_CFG_HOLD];
        cfg_awren <= reg_wdata[`FSC_CFG_AWREN];
        mode_byte <= reg_wdata[`FSC_CFG_MODE +: 8];
      end
      if (sw_wr_ctrl && reg_wdata[`FSC_CTRL_ABORT] && state != ST_IDLE) begin
        abort_req <= 1'b1;
      end
      if (sw_wr_ctrl && reg_wdata[`FSC_CTRL_START]) begin
        if (state != ST_IDLE || (quad_use && !cfg_qe)) begin
          refused <= 1'b1;
        end else begin
          cmd_op <= reg_wdata[7:0];
          pre    <= cfg_awren && f_needs_wel(reg_wdata[7:0]);
          state  <= ST_LAUNCH;
        end
      end
      case (state)
        ST_LAUNCH: begin
          cur_op     <= launch_op;
          sh         <= {launch_op, 24'h00_0000};
          phase      <= PH_OP;
          slots      <= 6'd8;
          bslot      <= 3'd0;
          bytes_left <= len_r;
          cnt        <= 8'h00;
          flash_cs_n <= 1'b0;
          state      <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (cnt == 8'h00) begin
            if (abort_req && phase == PH_DATA && (dir == DIR_RD || bslot == 3'd0)) begin
              state <= ST_HOLD;
              cnt   <= 8'h00;
            end else if (!stall) begin
              if (load_tx) begin
                sh[31:24] <= tx_masked;
                tx_full   <= 1'b0;
              end
              case (lanes)
                3'd2:    io_dat <= {2'b00, top[7:6]};
                3'd4:    io_dat <= top[7:4];
                default: io_dat <= {3'b000, top[7]};
              endcase
              cnt <= cnt + 8'h01;
            end
          end else if (cnt == CNT_RISE) begin
            flash_sclk <= 1'b1;
            case (lanes)
              3'd2:    sh <= {top[5:0], sh[23:0], 2'b00};
              3'd4:    sh <= {top[3:0], sh[23:0], 4'h0};
              default: sh <= {top[6:0], sh[23:0], 1'b0};
            endcase
            case (ld)
              3'd2:    rxs <= {rxs[5:0], io_q[1:0]};
              3'd4:    rxs <= {rxs[3:0], io_q[3:0]};
              default: rxs <= {rxs[6:0], io_q[1]};
            endcase
            cnt <= cnt + 8'h01;
          end else if (cnt == CNT_LAST) begin
            flash_sclk <= 1'b0;
            cnt        <= 8'h00;
            if (phase == PH_DATA) begin
              bslot <= bslot + 3'd1;
              if (bslot == bslot_last) begin
                bslot      <= 3'd0;
                bytes_left <= bytes_left - 16'h0001;
                if (dir == DIR_RD) begin
                  rx_byte <= rxs;
                  rx_full <= 1'b1;
                end
                if (bytes_left == 16'h0001) begin
                  state <= ST_HOLD;
                end
              end
            end else if (slots == 6'd1) begin
              phase <= nph;
              case (nph)
                PH_ADDR: begin
                  sh    <= {addr_r, 8'h00};
                  slots <= (la == 3'd4) ? 6'd6 : (la == 3'd2) ? 6'd12 : 6'd24;
                end
                PH_MODE: begin
                  sh    <= {mode_byte, 24'h00_0000};
                  slots <= (la == 3'd4) ? 6'd2 : 6'd4;
                end
                PH_DUMMY: begin
                  sh    <= 32'h0000_0000;
                  slots <= {2'b00, dmy};
                end
                PH_DATA: begin
                  bslot <= 3'd0;
                end
                default: begin
                  state <= ST_HOLD;
                end
              endcase
            end else begin
              slots <= slots - 6'd1;
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        ST_HOLD: begin
          if (cnt == GAP_LAST) begin
            flash_cs_n <= 1'b1;
            cnt        <= 8'h00;
            state      <= ST_GAP;
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        ST_GAP: begin
          if (cnt == GAP_LAST) begin
            cnt <= 8'h00;
            if (pre && !abort_req) begin
              pre   <= 1'b0;
              state <= ST_LAUNCH;
            end else begin
              pre       <= 1'b0;
              abort_req <= 1'b0;
              done      <= 1'b1;
              state     <= ST_IDLE;
            end
          end else begin
            cnt <= cnt + 8'h01;
          end
        end
        default: begin
          flash_cs_n <= 1'b1;
          flash_sclk <= 1'b0;
        end
      endcase
      if (reg_wr && reg_addr == `FSC_REG_TX && !tx_full) begin
        tx_byte <= reg_wdata[7:0];
        tx_full <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, unmapped reads zero

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `FSC_REG_CTRL:   reg_rdata <= {24'h00_0000, cmd_op};
        `FSC_REG_ADDR:   reg_rdata <= {8'h00, addr_r};
        `FSC_REG_LEN:    reg_rdata <= {16'h0000, len_r};
        `FSC_REG_TX:     reg_rdata <= {23'h00_0000, tx_full, tx_byte};
        `FSC_REG_RX:     reg_rdata <= {24'h00_0000, rx_byte};
        `FSC_REG_CFG:    reg_rdata <= {16'h0000, mode_byte, 3'b000, cfg_awren,
                                       cfg_hold, cfg_wp, cfg_qe, cfg_dc};
        `FSC_REG_STATUS: reg_rdata <= {27'h000_0000, refused, done, rx_full,
                                       tx_full, state != ST_IDLE};
        default:         reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // fsc_host

// *** fsc_host_checker.sv ***
// assertions on the flash host pins and register read port
// assumes a bind to fsc_host at its default link timing
`timescale 1ns/1ps
module fsc_host_checker #(
  parameter SCLK_HALF = 8,
  parameter CS_GAP    = 8
)(
  input wire        ref_clk,
  input wire        rst,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        flash_cs_n,
  input wire        flash_sclk,
  input wire [3:0]  io_out,
  input wire [3:0]  io_oe_n
);
  reg [7:0] hi_cnt;
  always @(posedge ref_clk or posedge rst) begin
    if (rst) hi_cnt <= 8'h00;
    else hi_cnt <= flash_sclk ? hi_cnt + 8'h01 : 8'h00;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_idle_a: assert property ($fell(rst) |-> flash_cs_n && !flash_sclk)
    else $error("link busy after reset");
  sclk_idle_a: assert property (flash_cs_n |-> !flash_sclk)
    else $error("clock runs while deselected");
  rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  sclk_high_a: assert property ($fell(flash_sclk) |-> hi_cnt == SCLK_HALF)
    else $error("clock high phase wrong");
  cs_hold_a: assert property ($fell(flash_sclk) |-> !flash_cs_n [*8])
    else $error("select released too soon");
  data_stable_a: assert property (flash_sclk && $past(flash_sclk) |-> $stable(io_out))
    else $error("data moved while clock high");
  cs_gap_a: assert property ($rose(flash_cs_n) |-> flash_cs_n [*8])
    else $error("deselect gap too short");
  idle_pins_a: assert property (flash_cs_n |-> io_oe_n == 4'b0010)
    else $error("idle pin drive wrong");
endmodule // fsc_host_checker

// *** fsc_flash_model.sv ***
// behavioural serial flash: status bytes, write latch, framing
// assumes mode 0 link, opcodes on io0, status bytes out on io1
`timescale 1ns/1ps
module fsc_flash_model (
  input  wire       cs_n,
  input  wire       sclk,
  input  wire [3:0] dq,
  output reg        so
);
  reg  [7:0] sr1 = 8'h00;
  reg  [7:0] sr2 = 8'h00;
  reg  [7:0] sr3 = 8'h20;
  reg  [7:0] op, sh;
  reg        armed = 1'b0;
  integer    n = 0;
  initial so = 1'b0;
  // shared pin holds the link only as a pause input with quad mode off
  wire       paused = !sr2[1] && !sr3[7] && !dq[3];
  wire       rdsr = op == 8'h05 || op == 8'h35 || op == 8'h15;
  wire [7:0] sel = op == 8'h05 ? sr1 : op == 8'h35 ? sr2 : sr3;
  always @(negedge cs_n) n = 0;
  always @(posedge sclk) begin
    if (!cs_n && !paused) begin
      sh = {sh[6:0], dq[0]};
      n = n + 1;
      if (n == 8) op = sh;
    end
  end
  // released output alternates so a stale bit never passes for data
  always @(negedge sclk or posedge cs_n) begin
    if (!cs_n && n >= 8 && rdsr) so = sel[7 - (n - 8) % 8];
    else so = ~so;
  end
  always @(posedge cs_n) begin
    // nothing is ever in flight, so a suspend sets no flag
    if (n == 8 && (op == 8'h7A || op == 8'h99 && armed)) sr2 = sr2 & 8'h7B;
    armed = n == 8 && op == 8'h66;
    if (n == 8 && (op == 8'h06 || op == 8'h04)) sr1[1] = op[1];
    if (n == 16 && sr1[1]) begin
      if (op == 8'h01) sr1 = {sh[7:2], sr1[1:0]};
      if (op == 8'h31) sr2 = sh & 8'h7B | sr2 & 8'hBC;
      if (op == 8'h11) sr3 = sh;
      if (op[3:0] == 4'h1) sr1[1] = 1'b0;
    end
  end
endmodule // fsc_flash_model

// *** fsc_host_tb.sv ***
// self-checking bench for the serial flash host controller
// assumes the behavioural flash model and the bound pin checker
`timescale 1ns/1ps
`include "fsc_defines.vh"
module fsc_host_tb;
  reg         ref_clk = 1'b0;
  reg         rst = 1'b1;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [7:0]  reg_addr = 8'h00;
  reg  [31:0] reg_wdata = 32'h0000_0000;
  reg  [31:0] rv, st;
  reg  [7:0]  rx [0:3];
  wire [31:0] reg_rdata;
  wire [3:0]  io_out, io_oe_n, io_in;
  wire        flash_cs_n, flash_sclk, so;
  integer     error_cnt = 0;
  integer     n_compared = 0;
  integer     nclk = 0;
  integer     i;
  // io0, io2 and io3 pulled up; io1 from the flash once released
  assign io_in = ~io_oe_n & io_out | io_oe_n & {2'b11, so, 1'b1};
  always #2.5 ref_clk = ~ref_clk;
  always @(negedge flash_cs_n) nclk = 0;
  always @(posedge flash_sclk) nclk = nclk + 1;
  fsc_host i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_cs_n(flash_cs_n),
    .flash_sclk(flash_sclk), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n));
  fsc_flash_model i_flash (.cs_n(flash_cs_n), .sclk(flash_sclk), .dq(io_in), .so(so));
  task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [7:0] a, output [31:0] d);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge ref_clk);
    end
  endtask
  // one whole frame; received bytes land in rx, done is cleared after
  task cmd(input [7:0] op, input [15:0] len, input [7:0] tx);
    integer k;
    integer n;
    begin
      n = 0;
      wr(`FSC_REG_LEN, {16'h0000, len});
      if (op[3:0] == 4'h1) wr(`FSC_REG_TX, {24'h00_0000, tx});
      wr(`FSC_REG_CTRL, {23'h00_0000, 1'b1, op});
      for (k = 0; k < 2000; k = k + 1) begin
        rd(`FSC_REG_STATUS, st);
        if (st[`FSC_ST_RXFULL] === 1'b1) begin
          rd(`FSC_REG_RX, rv);
          rx[n % 4] = rv[7:0];
          n = n + 1;
        end
        if (st[`FSC_ST_DONE] === 1'b1) break;
      end
      if (k == 2000) begin
        check(32'h0000_0000, 32'h0000_0001, "frame done");
        end_sim;
      end
      wr(`FSC_REG_STATUS, 32'h0000_0018);
    end
  endtask
  task end_sim;
    begin
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      rd(`FSC_REG_CFG, rv);
      check(rv, 32'h0000_000C, "cfg reset");
      rd(8'h1C, rv);
      check(rv, 32'h0000_0000, "unmapped");
      check({28'h000_0000, io_oe_n}, 32'h0000_0002, "idle drive");
      $display("test reset done");
    end
  endtask
  task t_status;
    begin
      cmd(`FSC_OP_WREN, 16'h0000, 8'h00);
      check(nclk, 32'h0000_0008, "wren clocks");
      cmd(`FSC_OP_WRSR2, 16'h0001, 8'h08);
      check(nclk, 32'h0000_0010, "write clocks");
      cmd(`FSC_OP_WREN, 16'h0000, 8'h00);
      cmd(`FSC_OP_WRSR2, 16'h0001, 8'h50);
      cmd(`FSC_OP_WRSR2, 16'h0001, 8'h00);
      cmd(`FSC_OP_RDSR2, 16'h0002, 8'h00);
      check(rx[0], 8'h58, "locks");
      check(rx[1], 8'h58, "repeat");
      cmd(`FSC_OP_WREN, 16'h0000, 8'h00);
      cmd(`FSC_OP_RDSR1, 16'h0001, 8'h00);
      check(rx[0], 8'h02, "latch set");
      cmd(`FSC_OP_WRSR1, 16'h0001, 8'h1C);
      cmd(`FSC_OP_WREN, 16'h0000, 8'h00);
      cmd(`FSC_OP_WRDI, 16'h0000, 8'h00);
      cmd(`FSC_OP_RDSR1, 16'h0001, 8'h00);
      check(rx[0], 8'h1C, "latch clear");
      cmd(`FSC_OP_RDSR3, 16'h0001, 8'h00);
      check(rx[0], 8'h20, "drive");
      cmd(`FSC_OP_WREN, 16'h0000, 8'h00);
      cmd(`FSC_OP_WRSR3, 16'h0001, 8'hFF);
      cmd(`FSC_OP_RDSR3, 16'h0001, 8'h00);
      check(rx[0], 8'hE1, "reserved");
      $display("test status done");
    end
  endtask
  // 03, 0B, then dual and quad io reads with each dummy setting
  task t_reads;
    begin
      wr(`FSC_REG_ADDR, 32'h0012_3456);
      for (i = 0; i < 6; i = i + 1) begin
        wr(`FSC_REG_CFG, {30'h0000_0000, i > 3, i > 1 && i[0]} | 32'h0000_000C);
        cmd(i < 1 ? 8'h03 : i < 2 ? 8'h0B : i < 4 ? 8'hBB : 8'hEB, 16'h0001, 8'h00);
        rv = i < 1 ? 8'h28 : i < 2 ? 8'h30 : i < 4 ? 8'h1C : 8'h16;
        rv = rv + (i > 1 && i[0] ? 8'h04 : 8'h00);
        check(nclk, rv, "read clocks");
      end
      $display("test reads done");
    end
  endtask
  task t_refuse;
    begin
      wr(`FSC_REG_CFG, 32'h0000_000C);
      wr(`FSC_REG_CTRL, {23'h00_0000, 1'b1, `FSC_OP_QIOREAD});
      rd(`FSC_REG_STATUS, st);
      check(st[`FSC_ST_REFUSED], 1'b1, "quad refused");
      check(flash_cs_n, 1'b1, "no frame");
      wr(`FSC_REG_STATUS, 32'h0000_0018);
      $display("test refuse done");
    end
  endtask
  // auto write-enable: a 06H frame goes ahead of the status write
  task t_auto;
    begin
      wr(`FSC_REG_CFG, 32'h0000_001C);
      cmd(`FSC_OP_WRSR1, 16'h0001, 8'h08);
      check(nclk, 32'h0000_0010, "auto frame");
      wr(`FSC_REG_CFG, 32'h0000_000C);
      cmd(`FSC_OP_RDSR1, 16'h0001, 8'h00);
      check(rx[0], 8'h08, "auto write");
      $display("test auto done");
    end
  endtask
  // long status read cut by an abort while the first byte waits in rx
  task t_abort;
    integer k;
    begin
      wr(`FSC_REG_LEN, 32'h0000_0100);
      wr(`FSC_REG_CTRL, {23'h00_0000, 1'b1, `FSC_OP_RDSR1});
      st = 32'h0000_0000;
      for (k = 0; k < 500 && st[`FSC_ST_RXFULL] !== 1'b1; k = k + 1)
        rd(`FSC_REG_STATUS, st);
      wr(`FSC_REG_CTRL, 32'h0000_0200);
      for (k = 0; k < 500 && st[`FSC_ST_DONE] !== 1'b1; k = k + 1)
        rd(`FSC_REG_STATUS, st);
      check(st[`FSC_ST_DONE], 1'b1, "abort done");
      if (st[`FSC_ST_DONE] !== 1'b1)
        end_sim;
      check(nclk, 32'h0000_0010, "abort clocks");
      rd(`FSC_REG_RX, rv);
      check(rv, 32'h0000_0008, "abort byte");
      wr(`FSC_REG_STATUS, 32'h0000_0018);
      $display("test abort done");
    end
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_status;
    t_reads;
    t_refuse;
    t_auto;
    t_abort;
    end_sim;
  end
endmodule // fsc_host_tb
bind fsc_host fsc_host_checker #(.SCLK_HALF(SCLK_HALF), .CS_GAP(CS_GAP)) i_chk (
  .ref_clk(ref_clk), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk), .io_out(io_out), .io_oe_n(io_oe_n));
